/* File: src/lcdrw_slave.sv */
`timescale 1ns/10ps
`include "lcdrw_regs.svh"
module lcdrw_slave
  import lcdrw_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  input wire logic BUS_ADDR_SELECT_PIN_IN,
  input wire logic SUBADDR_PIN_0_IN,
  input wire logic SUBADDR_PIN_1_IN,
  input wire logic SUBADDR_PIN_2_IN,
  input wire logic SYNC_N_IN,
  input wire logic OSC_TICK_IN,
  input wire logic ROW_STEP_IN,
  output logic SDA_OUT,
  output logic SDA_OE_OUT,
  output logic [31:0] SEG_OUT,
  output logic [1:0] ROW_OUT,
  output logic [1:0] MODE_OUT,
  output logic BIAS_OUT
);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [6:0] meta_q, meta_d;
  logic [6:0] sync_q, sync_d;
  logic scl_p_q, scl_p_d, sda_p_q, sda_p_d;
  logic scl_s, sda_s, sel_s, sync_n_s;
  logic [2:0] pins_s;

  always_comb begin
    meta_d = {SYNC_N_IN, SUBADDR_PIN_2_IN, SUBADDR_PIN_1_IN, SUBADDR_PIN_0_IN,
              BUS_ADDR_SELECT_PIN_IN, SDA_IN, SCL_IN};
    sync_d = meta_q;
    scl_p_d = sync_q[0];
    sda_p_d = sync_q[1];
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      meta_q <= 7'h7f;
      sync_q <= 7'h7f;
      scl_p_q <= 1'h1;
      sda_p_q <= 1'h1;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      scl_p_q <= scl_p_d;
      sda_p_q <= sda_p_d;
    end
  end

  assign scl_s = sync_q[0];
  assign sda_s = sync_q[1];
  assign sel_s = sync_q[2];
  assign pins_s = sync_q[5:3];
  assign sync_n_s = sync_q[6];

  // ****************************************
  // Bus receiver
  // ****************************************
  lcdrw_state_t st_q, st_d;
  lcdrw_phase_t ph_q, ph_d;
  logic [7:0] shift_q, shift_d;
  logic [3:0] bitcnt_q, bitcnt_d;
  logic oe_q, oe_d;
  logic start_ev, stop_ev, scl_rise, scl_fall;
  logic push, ok, in_ready;
  logic [4:0] sub_q;
  logic sub_match;

  assign scl_rise = scl_s & ~scl_p_q;
  assign scl_fall = ~scl_s & scl_p_q;
  assign start_ev = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_ev = scl_s & scl_p_q & ~sda_p_q & sda_s;
  assign sub_match = (sub_q[2:0] == pins_s);

  always_comb begin
    st_d = st_q;
    ph_d = ph_q;
    shift_d = shift_q;
    bitcnt_d = bitcnt_q;
    oe_d = oe_q;
    push = 1'h0;
    ok = 1'h0;
    if (start_ev) begin
      st_d = LCDRW_ST_RECV;
      ph_d = LCDRW_PH_ADDR;
      bitcnt_d = 4'h0;
      oe_d = 1'h0;
    end else if (stop_ev) begin
      st_d = LCDRW_ST_IDLE;
      oe_d = 1'h0;
    end else begin
      unique case (st_q)
        LCDRW_ST_IDLE, LCDRW_ST_IGNORE: begin
        end
        LCDRW_ST_RECV: begin
          if (scl_rise && bitcnt_q != `LCDRW_BITS_PER_BYTE) begin
            shift_d = {shift_q[6:0], sda_s};
            bitcnt_d = bitcnt_q + 4'h1;
          end else if (scl_fall && bitcnt_q == `LCDRW_BITS_PER_BYTE) begin
            unique case (ph_q)
              LCDRW_PH_ADDR: begin
                // Read requests and the other select level are ignored
                ok = shift_q[7:2] == `LCDRW_ADDR_TOP && shift_q[`LCDRW_ADDR_SEL_BIT] == sel_s
                     && !shift_q[`LCDRW_ADDR_RW_BIT];
                oe_d = ok;
              end
              LCDRW_PH_CMD: begin
                ok = in_ready;
                oe_d = ok;
              end
              default: begin
                ok = in_ready;
                oe_d = in_ready & sub_match;
              end
            endcase
            if (ok) begin
              st_d = LCDRW_ST_ACK;
              push = (ph_q != LCDRW_PH_ADDR);
              if (ph_q == LCDRW_PH_ADDR) begin
                ph_d = LCDRW_PH_CMD;
              end else if (ph_q == LCDRW_PH_CMD && !shift_q[`LCDRW_CONT_BIT]) begin
                ph_d = LCDRW_PH_DATA;
              end
            end else begin
              st_d = LCDRW_ST_IGNORE;
            end
          end
        end
        LCDRW_ST_ACK: begin
          if (scl_fall) begin
            oe_d = 1'h0;
            st_d = LCDRW_ST_RECV;
            bitcnt_d = 4'h0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      st_q <= LCDRW_ST_IDLE;
      ph_q <= LCDRW_PH_ADDR;
      shift_q <= 8'h00;
      bitcnt_q <= 4'h0;
      oe_q <= 1'h0;
    end else begin
      st_q <= st_d;
      ph_q <= ph_d;
      shift_q <= shift_d;
      bitcnt_q <= bitcnt_d;
      oe_q <= oe_d;
    end
  end

  // ****************************************
  // Two-entry byte buffer
  // ****************************************
  logic [8:0] fifo_q [2];
  logic [8:0] fifo_d [2];
  logic wp_q, wp_d, rp_q, rp_d;
  logic [1:0] cnt_q, cnt_d;
  logic out_valid, out_ready, pop;
  logic [8:0] out_word;

  assign in_ready = (cnt_q != `LCDRW_FIFO_DEPTH);
  assign out_valid = (cnt_q != 2'h0);
  assign out_ready = ~ROW_STEP_IN;
  assign pop = out_valid & out_ready;
  assign out_word = fifo_q[rp_q];

  always_comb begin
    fifo_d = fifo_q;
    wp_d = wp_q;
    rp_d = rp_q;
    if (push && in_ready) begin
      fifo_d[wp_q] = {ph_q == LCDRW_PH_DATA, shift_q};
      wp_d = ~wp_q;
    end
    if (pop) begin
      rp_d = ~rp_q;
    end
    cnt_d = cnt_q + {1'h0, push & in_ready} - {1'h0, pop};
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      fifo_q[0] <= 9'h000;
      fifo_q[1] <= 9'h000;
      wp_q <= 1'h0;
      rp_q <= 1'h0;
      cnt_q <= 2'h0;
    end else begin
      fifo_q <= fifo_d;
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  // ****************************************
  // Command decode and RAM store
  // ****************************************
  logic [3:0] ram_q [`LCDRW_RAM_WORDS];
  logic [3:0] ram_d [`LCDRW_RAM_WORDS];
  logic [5:0] ptr_q, ptr_d;
  logic [4:0] sub_d;
  lcdrw_mode_t mode_q, mode_d;
  logic en_q, en_d, bias_q, bias_d, ibank_q, ibank_d, obank_q, obank_d;
  logic bblink_q, bblink_d;
  logic [1:0] bf_q, bf_d;
  logic [7:0] cmd;
  logic [5:0] inc, nxt;
  logic [6:0] a;
  logic [1:0] b;

  assign cmd = out_word[7:0];

  always_comb begin
    ram_d = ram_q;
    ptr_d = ptr_q;
    sub_d = sub_q;
    mode_d = mode_q;
    en_d = en_q;
    bias_d = bias_q;
    ibank_d = ibank_q;
    obank_d = obank_q;
    bblink_d = bblink_q;
    bf_d = bf_q;
    a = 7'h00;
    b = 2'h0;
    unique case (mode_q)
      LCDRW_MODE_STATIC: inc = `LCDRW_INC_STATIC;
      LCDRW_MODE_1_2: inc = `LCDRW_INC_1_2;
      LCDRW_MODE_1_3: inc = `LCDRW_INC_1_3;
      LCDRW_MODE_1_4: inc = `LCDRW_INC_1_4;
    endcase
    nxt = ptr_q + inc;
    if (pop && out_word[8]) begin
      if (sub_match) begin
        for (int j = 0; j < 8; j++) begin
          unique case (mode_q)
            LCDRW_MODE_STATIC: begin
              a = 7'(j);
              b = ibank_q ? `LCDRW_BANK_OFFS : 2'h0;
            end
            LCDRW_MODE_1_2: begin
              a = 7'(j / 2);
              b = 2'(j % 2) + (ibank_q ? `LCDRW_BANK_OFFS : 2'h0);
            end
            LCDRW_MODE_1_3: begin
              a = 7'(j / 3);
              b = 2'(j % 3);
            end
            LCDRW_MODE_1_4: begin
              a = 7'(j / 4);
              b = 2'(j % 4);
            end
          endcase
          a = a + {1'h0, ptr_q};
          if (a < 7'(`LCDRW_RAM_WORDS)) begin
            ram_d[a[4:0]][b] = cmd[7 - j];
          end
        end
      end
      // Past the last location the next subaddress takes over
      if (nxt >= `LCDRW_PTR_WRAP) begin
        ptr_d = 6'h00;
        sub_d = sub_q + 5'h01;
      end else begin
        ptr_d = nxt;
      end
    end else if (pop) begin
      if (!cmd[`LCDRW_OP_BIT]) begin
        ptr_d = cmd[5:0];
      end else if (cmd[6:3] == `LCDRW_DEVSEL_OP) begin
        sub_d = {2'h0, cmd[2:0]};
      end else if (cmd[6:5] == `LCDRW_MODE_OP) begin
        en_d = cmd[`LCDRW_MODE_EN_BIT];
        bias_d = cmd[`LCDRW_MODE_BIAS_BIT];
        mode_d = lcdrw_mode_t'(cmd[1:0]);
      end else if (cmd[6:2] == `LCDRW_BANK_OP) begin
        ibank_d = cmd[`LCDRW_BANK_IN_BIT];
        obank_d = cmd[`LCDRW_BANK_OUT_BIT];
      end else if (cmd[6:3] == `LCDRW_BLINK_OP) begin
        bblink_d = cmd[`LCDRW_BLINK_A_BIT];
        bf_d = cmd[1:0];
      end
    end
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      for (int i = 0; i < `LCDRW_RAM_WORDS; i++) begin
        ram_q[i] <= 4'h0;
      end
      ptr_q <= 6'h00;
      sub_q <= 5'h00;
      mode_q <= LCDRW_MODE_1_4;
      en_q <= 1'h0;
      bias_q <= 1'h0;
      ibank_q <= 1'h0;
      obank_q <= 1'h0;
      bblink_q <= 1'h0;
      bf_q <= `LCDRW_BLINK_OFF;
    end else begin
      ram_q <= ram_d;
      ptr_q <= ptr_d;
      sub_q <= sub_d;
      mode_q <= mode_d;
      en_q <= en_d;
      bias_q <= bias_d;
      ibank_q <= ibank_d;
      obank_q <= obank_d;
      bblink_q <= bblink_d;
      bf_q <= bf_d;
    end
  end

  // ****************************************
  // Blinker, row sequence and display latch
  // ****************************************
  logic [10:0] bdiv_q, bdiv_d, half;
  logic phase_q, phase_d;
  logic [1:0] row_q, row_d, last_row, obit;
  logic [31:0] seg_d;
  logic alt, blank;

  always_comb begin
    unique case (bf_q)
      `LCDRW_BLINK_2HZ: half = `LCDRW_BLINK_HALF_2HZ;
      `LCDRW_BLINK_1HZ: half = `LCDRW_BLINK_HALF_1HZ;
      default: half = `LCDRW_BLINK_HALF_0HZ5;
    endcase
    bdiv_d = bdiv_q;
    phase_d = phase_q;
    if (bf_q == `LCDRW_BLINK_OFF) begin
      bdiv_d = 11'h000;
      phase_d = 1'h0;
    end else if (OSC_TICK_IN) begin
      if (bdiv_q >= half - 11'h001) begin
        bdiv_d = 11'h000;
        phase_d = ~phase_q;
      end else begin
        bdiv_d = bdiv_q + 11'h001;
      end
    end
    unique case (mode_q)
      LCDRW_MODE_STATIC: last_row = 2'h0;
      LCDRW_MODE_1_2: last_row = 2'h1;
      LCDRW_MODE_1_3: last_row = 2'h2;
      LCDRW_MODE_1_4: last_row = 2'h3;
    endcase
    row_d = row_q;
    if (!sync_n_s) begin
      row_d = last_row;
    end else if (ROW_STEP_IN) begin
      row_d = (row_q >= last_row) ? 2'h0 : row_q + 2'h1;
    end
    alt = obank_q;
    blank = ~en_q;
    if (bblink_q && (mode_q == LCDRW_MODE_STATIC || mode_q == LCDRW_MODE_1_2)) begin
      alt = obank_q ^ phase_q;
    end else begin
      blank = ~en_q | phase_q;
    end
    obit = row_q;
    if (alt && (mode_q == LCDRW_MODE_STATIC || mode_q == LCDRW_MODE_1_2)) begin
      obit = row_q + `LCDRW_BANK_OFFS;
    end
    for (int i = 0; i < `LCDRW_RAM_WORDS; i++) begin
      seg_d[i] = ram_q[i][obit] & ~blank;
    end
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      bdiv_q <= 11'h000;
      phase_q <= 1'h0;
      row_q <= 2'h0;
      SEG_OUT <= 32'h0000_0000;
      ROW_OUT <= 2'h0;
      MODE_OUT <= 2'h0;
      BIAS_OUT <= 1'h0;
      SDA_OUT <= 1'h0;
      SDA_OE_OUT <= 1'h0;
    end else begin
      bdiv_q <= bdiv_d;
      phase_q <= phase_d;
      row_q <= row_d;
      SEG_OUT <= seg_d;
      ROW_OUT <= row_q;
      MODE_OUT <= mode_q;
      BIAS_OUT <= bias_q;
      SDA_OUT <= 1'h0;
      SDA_OE_OUT <= oe_q;
    end
  end
endmodule // lcdrw_slave

/* File: src/lcdrw_regs.svh */
`ifndef LCDRW_REGS_SVH
`define LCDRW_REGS_SVH
// ****************************************
// Bus address and command decode
// ****************************************
`define LCDRW_ADDR_TOP 6'h1c
`define LCDRW_ADDR_SEL_BIT 1
`define LCDRW_ADDR_RW_BIT 0
`define LCDRW_CONT_BIT 7
`define LCDRW_OP_BIT 6
`define LCDRW_DEVSEL_OP 4'hc
`define LCDRW_BLINK_OP 4'he
`define LCDRW_MODE_OP 2'h2
`define LCDRW_BANK_OP 5'h1e
`define LCDRW_MODE_EN_BIT 3
`define LCDRW_MODE_BIAS_BIT 2
`define LCDRW_BLINK_A_BIT 2
`define LCDRW_BANK_IN_BIT 1
`define LCDRW_BANK_OUT_BIT 0
// ****************************************
// Counts, sizes and reset values
// ****************************************
`define LCDRW_BITS_PER_BYTE 4'h8
`define LCDRW_RAM_WORDS 32
`define LCDRW_PTR_WRAP 6'h28
`define LCDRW_INC_STATIC 6'h08
`define LCDRW_INC_1_2 6'h04
`define LCDRW_INC_1_3 6'h03
`define LCDRW_INC_1_4 6'h02
`define LCDRW_BANK_OFFS 2'h2
`define LCDRW_BLINK_HALF_2HZ 11'h180
`define LCDRW_BLINK_HALF_1HZ 11'h300
`define LCDRW_BLINK_HALF_0HZ5 11'h600
`define LCDRW_BLINK_OFF 2'h0
`define LCDRW_BLINK_2HZ 2'h1
`define LCDRW_BLINK_1HZ 2'h2
`define LCDRW_FIFO_DEPTH 2'h2
`endif

/* File: src/lcdrw_pkg.sv */
package lcdrw_pkg;
  typedef enum logic [1:0] {
    LCDRW_ST_IDLE = 2'h0,
    LCDRW_ST_RECV = 2'h1,
    LCDRW_ST_ACK = 2'h2,
    LCDRW_ST_IGNORE = 2'h3
  } lcdrw_state_t;
  typedef enum logic [1:0] {
    LCDRW_PH_ADDR = 2'h0,
    LCDRW_PH_CMD = 2'h1,
    LCDRW_PH_DATA = 2'h2
  } lcdrw_phase_t;
  typedef enum logic [1:0] {
    LCDRW_MODE_1_4 = 2'h0,
    LCDRW_MODE_STATIC = 2'h1,
    LCDRW_MODE_1_2 = 2'h2,
    LCDRW_MODE_1_3 = 2'h3
  } lcdrw_mode_t;
endpackage

/* File: bench/lcdrw_slave_monitor.sv */
`timescale 1ns/10ps
module lcdrw_slave_monitor
  import lcdrw_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  input wire logic SYNC_N_IN,
  input wire logic OSC_TICK_IN,
  input wire logic ROW_STEP_IN,
  input wire logic SDA_OUT,
  input wire logic SDA_OE_OUT,
  input wire logic [31:0] SEG_OUT,
  input wire logic [1:0] ROW_OUT,
  input wire logic [1:0] MODE_OUT,
  input wire logic BIAS_OUT
);
  // ****************************************
  // Bus and display checks
  // ****************************************
  default clocking @(posedge CLK_IN);
  endclocking
  default disable iff (RST_IN);
  sda_data_a: assert property (SDA_OUT == 1'b0)
    else $error("sda data output not low");
  ack_start_a: assert property ($rose(SDA_OE_OUT) |-> !SCL_IN)
    else $error("ack started while scl high");
  ack_holds_a: assert property (SDA_OE_OUT && SCL_IN |=> SDA_OE_OUT)
    else $error("ack dropped during scl high");
  ack_ends_a: assert property ($fell(SCL_IN) && SDA_OE_OUT |-> ##[1:6] !SDA_OE_OUT)
    else $error("ack not released after ninth clock");
  mode_idle_a: assert property ((SCL_IN && SDA_IN)[*8] |=> $stable(MODE_OUT) && $stable(BIAS_OUT))
    else $error("mode changed on idle bus");
  seg_quiet_a: assert property ((SCL_IN && SDA_IN && SYNC_N_IN && !ROW_STEP_IN && !OSC_TICK_IN)[*8]
    |=> $stable(SEG_OUT) && $stable(ROW_OUT))
    else $error("display changed without cause");
  sync_four_a: assert property ((!SYNC_N_IN && MODE_OUT == LCDRW_MODE_1_4)[*5] |-> ROW_OUT == 2'h3)
    else $error("sync did not force row 3");
  sync_three_a: assert property ((!SYNC_N_IN && MODE_OUT == LCDRW_MODE_1_3)[*5] |-> ROW_OUT == 2'h2)
    else $error("sync did not force row 2");
  reset_out_a: assert property ($fell(RST_IN) |-> SEG_OUT == 32'h0000_0000 && MODE_OUT == 2'h0
    && !SDA_OE_OUT && !BIAS_OUT)
    else $error("outputs not cleared by reset");
endmodule // lcdrw_slave_monitor

bind lcdrw_slave lcdrw_slave_monitor lcdrw_slave_monitor_inst (.CLK_IN(CLK_IN), .RST_IN(RST_IN),
  .SCL_IN(SCL_IN), .SDA_IN(SDA_IN), .SYNC_N_IN(SYNC_N_IN), .OSC_TICK_IN(OSC_TICK_IN),
  .ROW_STEP_IN(ROW_STEP_IN), .SDA_OUT(SDA_OUT), .SDA_OE_OUT(SDA_OE_OUT), .SEG_OUT(SEG_OUT),
  .ROW_OUT(ROW_OUT), .MODE_OUT(MODE_OUT), .BIAS_OUT(BIAS_OUT));

/* File: bench/lcdrw_i2c_master.sv */
`timescale 1ns/10ps
module lcdrw_i2c_master (
  input wire logic clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_low_out
);
  // ****************************************
  // Bus master, SCL stands high between frames
  // ****************************************
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic start_cond;
    sda_low_out <= 1'b0;
    tick(6);
    scl_out <= 1'b1;
    tick(12);
    sda_low_out <= 1'b1;
    tick(12);
    scl_out <= 1'b0;
    tick(6);
  endtask
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_low_out <= !b[i];
      tick(6);
      scl_out <= 1'b1;
      tick(12);
      scl_out <= 1'b0;
      tick(6);
    end
    sda_low_out <= 1'b0;
    tick(6);
    scl_out <= 1'b1;
    tick(6);
    ack = !sda_in;
    tick(6);
    scl_out <= 1'b0;
    tick(6);
  endtask
  task automatic stop_cond;
    sda_low_out <= 1'b1;
    tick(6);
    scl_out <= 1'b1;
    tick(12);
    sda_low_out <= 1'b0;
    tick(24);
  endtask
endmodule // lcdrw_i2c_master

/* File: bench/lcdrw_slave_bench.sv */
`timescale 1ns/10ps
module lcdrw_slave_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sel = 1'b0;
  logic [2:0] sub = 3'h0;
  logic sync_n = 1'b1;
  logic osc_tick = 1'b0;
  logic osc_en = 1'b0;
  logic row_step = 1'b0;
  logic scl;
  logic sda_m;
  logic sda_oe;
  logic sda_out;
  logic [31:0] seg;
  logic [1:0] row;
  logic [1:0] mode;
  logic bias;
  wire sda_wire = !(sda_m || sda_oe);
  int bad_count = 0;
  int check_count = 0;
  int ticks;
  logic [7:0] addr_tab [5] = '{8'h70, 8'h72, 8'h71, 8'h72, 8'h60};
  logic sel_tab [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
  logic ack_tab [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
  int rows_tab [4] = '{4, 1, 2, 3};
  int inc_tab [4] = '{2, 8, 4, 3};
  // ****************************************
  // Clock, pulses and instances
  // ****************************************
  always #50 clk = !clk;
  always @(posedge clk) osc_tick <= osc_en && !osc_tick;
  lcdrw_slave lcdrw_slave_inst (.CLK_IN(clk), .RST_IN(rst), .SCL_IN(scl), .SDA_IN(sda_wire),
    .BUS_ADDR_SELECT_PIN_IN(sel), .SUBADDR_PIN_0_IN(sub[0]), .SUBADDR_PIN_1_IN(sub[1]),
    .SUBADDR_PIN_2_IN(sub[2]), .SYNC_N_IN(sync_n), .OSC_TICK_IN(osc_tick), .ROW_STEP_IN(row_step),
    .SDA_OUT(sda_out), .SDA_OE_OUT(sda_oe), .SEG_OUT(seg), .ROW_OUT(row), .MODE_OUT(mode),
    .BIAS_OUT(bias));
  lcdrw_i2c_master lcdrw_i2c_master_inst (.clk_in(clk), .sda_in(sda_wire), .scl_out(scl),
    .sda_low_out(sda_m));
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] expd);
    check_count++;
    if (seen !== expd) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, expd, seen);
    end
  endtask
  task automatic send(input logic [7:0] b, input logic exp_ack);
    logic ack;
    lcdrw_i2c_master_inst.send_byte(b, ack);
    check("ack", ack, exp_ack);
  endtask
  task automatic open_xfer;
    lcdrw_i2c_master_inst.start_cond();
    send(8'h70, 1'b1);
  endtask
  task automatic close_xfer;
    lcdrw_i2c_master_inst.stop_cond();
    tick(8);
  endtask
  task automatic do_reset;
    rst <= 1'b1;
    tick(10);
    rst <= 1'b0;
    tick(4);
  endtask
  task automatic end_test(input string name);
    $display("Test %s finished", name);
  endtask
  task automatic finish_test;
    $display("Checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    do_reset();
    check("reset seg", seg, 32'h0000_0000);
    check("reset mode", mode, 2'h0);
    check("reset ack", sda_oe, 1'b0);
    end_test("reset");
    for (int i = 0; i < 5; i++) begin
      sel <= sel_tab[i];
      tick(4);
      lcdrw_i2c_master_inst.start_cond();
      send(addr_tab[i], ack_tab[i]);
      close_xfer();
    end
    end_test("address");
    for (int m = 0; m < 4; m++) begin
      do_reset();
      open_xfer();
      send(8'h4c | 8'(m), 1'b1);
      open_xfer();
      send(8'h00, 1'b1);
      send(8'h80, 1'b1);
      send(8'h80, 1'b1);
      close_xfer();
      check("mode", mode, m);
      check("bias", bias, 1'b1);
      check("seg", seg, 32'h0000_0001 | (32'h0000_0001 << inc_tab[m]));
      sync_n <= 1'b0;
      tick(6);
      check("sync row", row, rows_tab[m] - 1);
      sync_n <= 1'b1;
      tick(4);
      for (int r = 0; r <= rows_tab[m]; r++) begin
        row_step <= 1'b1;
        tick(1);
        row_step <= 1'b0;
        tick(4);
        check("row", row, r % rows_tab[m]);
      end
    end
    end_test("modes");
    open_xfer();
    send(8'he1, 1'b1);
    send(8'h04, 1'b1);
    send(8'hff, 1'b0);
    close_xfer();
    check("seg", seg, 32'h0000_0009);
    sub <= 3'h1;
    tick(4);
    open_xfer();
    send(8'he1, 1'b1);
    send(8'h04, 1'b1);
    send(8'hff, 1'b1);
    close_xfer();
    check("seg", seg, 32'h0000_0079);
    end_test("subaddress");
    sub <= 3'h0;
    do_reset();
    open_xfer();
    send(8'hc9, 1'b1);
    send(8'hfa, 1'b1);
    send(8'h00, 1'b1);
    send(8'hff, 1'b1);
    close_xfer();
    check("seg", seg, 32'h0000_0000);
    open_xfer();
    send(8'h79, 1'b1);
    close_xfer();
    check("seg", seg, 32'h0000_00ff);
    open_xfer();
    send(8'h41, 1'b1);
    close_xfer();
    check("seg off", seg, 32'h0000_0000);
    open_xfer();
    send(8'h49, 1'b1);
    close_xfer();
    check("seg on", seg, 32'h0000_00ff);
    end_test("bank");
    osc_en <= 1'b1;
    for (int bf = 1; bf < 4; bf++) begin
      open_xfer();
      send(8'h70 | 8'(bf), 1'b1);
      close_xfer();
      for (int w = 0; w < 8000 && seg === 32'h0000_0000; w++) tick(1);
      for (int w = 0; w < 8000 && seg !== 32'h0000_0000; w++) tick(1);
      ticks = 0;
      for (int w = 0; w < 8000 && seg === 32'h0000_0000; w++) begin
        tick(1);
        ticks += 32'(osc_tick);
      end
      check("blink ticks", ticks, 384 << (bf - 1));
    end
    open_xfer();
    send(8'hf8, 1'b1);
    send(8'h75, 1'b1);
    close_xfer();
    for (int w = 0; w < 8000 && seg !== 32'h0000_00ff; w++) tick(1);
    check("bank blink", seg, 32'h0000_00ff);
    for (int w = 0; w < 8000 && seg !== 32'h0000_0000; w++) tick(1);
    check("bank blink", seg, 32'h0000_0000);
    end_test("blink");
    finish_test();
  end
  initial begin
    tick(60000);
    bad_count++;
    finish_test();
  end
endmodule // lcdrw_slave_bench
